//--- core/adcseq_defs.vh
// Constants for the converter sequence controller and status block.
// Assumes inclusion by bare name from the core design file.
`ifndef ADCSEQ_DEFS_VH
`define ADCSEQ_DEFS_VH
// ****************************************
// Register word indices (byte address divided by four)
// ****************************************
`define ADCSEQ_IDX_CTL2 8'h62
`define ADCSEQ_IDX_CTL3 8'h63
`define ADCSEQ_IDX_TIM 8'h64
`define ADCSEQ_IDX_SEQ 8'h65
`define ADCSEQ_IDX_STAT0 8'h66
`define ADCSEQ_IDX_STAT1 8'h67
`define ADCSEQ_IDX_RES0 8'h70
`define ADCSEQ_ADR_W 10
// ****************************************
// Field positions
// ****************************************
`define ADCSEQ_CTL2_FAST_FLAG_CLEAR 0
`define ADCSEQ_CTL2_TEST 1
`define ADCSEQ_CTL3_ONE 3
`define ADCSEQ_SEQ_EIGHT 6
`define ADCSEQ_SEQ_CONT 5
`define ADCSEQ_SEQ_SWEEP 4
`define ADCSEQ_SEQ_SPEC 3
`define ADCSEQ_STAT0_SCF 7
// ****************************************
// Values
// ****************************************
`define ADCSEQ_RST8 8'h00
`define ADCSEQ_RST10 10'h000
`define ADCSEQ_CNT0 3'h0
`define ADCSEQ_LAST1 3'h0
`define ADCSEQ_LAST4 3'h3
`define ADCSEQ_LAST8 3'h7
`define ADCSEQ_CH_ONE 3'h1
`define ADCSEQ_SPEC_HI 3'h4
`define ADCSEQ_SPEC_LO 3'h5
`define ADCSEQ_SPEC_MID 3'h6
`define ADCSEQ_SPEC_TOP 3'h7
`define ADCSEQ_SEL_RSV 4'hF
`define ADCSEQ_SEL_SPEC 4'h8
`endif

//--- core/adcseq_core.v
// Sequence controller, status flags and result file of an on-chip converter.
// Assumes a classic Wishbone master on clk and an analog core with start/done handshake.
// Operation
// - Single mode samples the chosen channel only
// - Sweep starts at code, then increments
// - Channel code wraps from seven to zero
// - Special mode converts internal channels
// - Special codes select high, low, midpoint
// - Reference conversions give FF, 00, 7F
// - Normal code n selects input n
// - Sweep: result k holds channel start plus k
// - No sweep: one, four or eight same-channel conversions
// - One-bit gives a single conversion unless eight set
// - Sequence done flag set per sequence
// - Done flag cleared by write or fast-mode result read
// - Counter points at result, resets per sequence
// - Conversion flag n set with result n
// - Slow clear needs status read first
// - Fast clear on own result read
// - Status read-only except test mode
// - Control write clears all flags
// - Length coding four, one, eight
// - Control write aborts and restarts sequence
// - Continuous mode repeats, else idles
`timescale 1ns/10ps
`default_nettype none
`include "adcseq_defs.vh"
module adcseq_core
(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`ADCSEQ_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Analog core
  output reg conv_start_o,
  output reg [3:0] conv_sel_o,
  input wire conv_done_i,
  input wire [9:0] conv_data_i,
  // Status
  output wire busy_o
);
  localparam ST_IDLE = 2'b00;
  localparam ST_START = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [1:0] state_q;
  reg [7:0] ctl2_q;
  reg [7:0] ctl3_q;
  reg [7:0] tim_q;
  reg [7:0] seq_q;
  reg seq_done_q;
  reg [7:0] ccf_q;
  reg [7:0] armed_q;
  reg [2:0] cnt_q;
  reg [2:0] pos_q;
  reg [2:0] ch_q;
  reg [9:0] res_q [0:7];
  reg done_s1_q;
  reg done_s2_q;
  reg done_s3_q;
  reg [9:0] data_s1_q;
  reg [9:0] data_s2_q;

  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0] idx = wb_adr_i[`ADCSEQ_ADR_W-1:2];
  wire wr = acc & wb_we_i & wb_sel_i[0];
  wire rd = acc & ~wb_we_i;
  wire fast = ctl2_q[`ADCSEQ_CTL2_FAST_FLAG_CLEAR];
  wire test = ctl2_q[`ADCSEQ_CTL2_TEST];
  wire sweep = seq_q[`ADCSEQ_SEQ_SWEEP];
  wire spec = seq_q[`ADCSEQ_SEQ_SPEC];
  wire [2:0] code = seq_q[2:0];
  wire ctl_wr = wr & ((idx == `ADCSEQ_IDX_TIM) | (idx == `ADCSEQ_IDX_SEQ));
  wire res_hit = (idx[7:3] == `ADCSEQ_IDX_RES0 >> 3);
  wire [2:0] res_n = idx[2:0];
  wire res_rd = rd & res_hit;
  wire stat1_rd = rd & (idx == `ADCSEQ_IDX_STAT1);
  wire conv_end = done_s2_q & ~done_s3_q;
  wire st0_wr = wr & test & (idx == `ADCSEQ_IDX_STAT0);
  wire st1_wr = wr & test & (idx == `ADCSEQ_IDX_STAT1);
  reg [2:0] last_pos;
  reg [2:0] chan;
  reg [7:0] rdata;
  reg [7:0] ccf_d;
  reg [7:0] armed_d;
  reg seq_done_d;
  integer i;

  assign busy_o = (state_q != ST_IDLE);

  // ****************************************
  // Sequence length and channel choice
  // ****************************************
  always @*
  begin
    if (seq_q[`ADCSEQ_SEQ_EIGHT])
      last_pos = `ADCSEQ_LAST8;
    else if (ctl3_q[`ADCSEQ_CTL3_ONE])
      last_pos = `ADCSEQ_LAST1;
    else
      last_pos = `ADCSEQ_LAST4;
    if (sweep)
      chan = ch_q;
    else
      chan = code;
  end

  // ****************************************
  // Register read mux
  // ****************************************
  always @*
  begin
    rdata = `ADCSEQ_RST8;
    if (res_hit)
      rdata = res_q[res_n][7:0];
    else
    begin
      case (idx)
        `ADCSEQ_IDX_CTL2: rdata = ctl2_q;
        `ADCSEQ_IDX_CTL3: rdata = ctl3_q;
        `ADCSEQ_IDX_TIM: rdata = tim_q;
        `ADCSEQ_IDX_SEQ: rdata = seq_q;
        `ADCSEQ_IDX_STAT0: rdata = {seq_done_q, 4'h0, cnt_q};
        `ADCSEQ_IDX_STAT1: rdata = ccf_q;
        default: rdata = `ADCSEQ_RST8;
      endcase
    end
  end

  // ****************************************
  // Flag next values
  // ****************************************
  always @*
  begin
    ccf_d = ccf_q;
    armed_d = armed_q;
    seq_done_d = seq_done_q;
    if (stat1_rd)
      armed_d = ccf_q;
    if (res_rd)
    begin
      if (fast)
      begin
        ccf_d[res_n] = 1'b0;
        seq_done_d = 1'b0;
      end
      else if (armed_q[res_n])
      begin
        ccf_d[res_n] = 1'b0;
        armed_d[res_n] = 1'b0;
      end
    end
    if (st1_wr)
      ccf_d = wb_dat_i[7:0];
    if (st0_wr)
      seq_done_d = wb_dat_i[`ADCSEQ_STAT0_SCF];
    if (state_q == ST_WAIT && conv_end)
    begin
      ccf_d[cnt_q] = 1'b1;
      if (pos_q == last_pos)
        seq_done_d = 1'b1;
    end
    if (ctl_wr)
    begin
      ccf_d = `ADCSEQ_RST8;
      armed_d = `ADCSEQ_RST8;
      seq_done_d = 1'b0;
    end
  end

  // ****************************************
  // Bus, control registers and sequencer
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctl2_q <= `ADCSEQ_RST8;
      ctl3_q <= `ADCSEQ_RST8;
      tim_q <= `ADCSEQ_RST8;
      seq_q <= `ADCSEQ_RST8;
      seq_done_q <= 1'b0;
      ccf_q <= `ADCSEQ_RST8;
      armed_q <= `ADCSEQ_RST8;
      cnt_q <= `ADCSEQ_CNT0;
      pos_q <= `ADCSEQ_CNT0;
      ch_q <= `ADCSEQ_CNT0;
      state_q <= ST_IDLE;
      conv_start_o <= 1'b0;
      conv_sel_o <= `ADCSEQ_SEL_RSV;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      data_s1_q <= `ADCSEQ_RST10;
      data_s2_q <= `ADCSEQ_RST10;
      for (i = 0; i < 8; i = i + 1)
        res_q[i] <= `ADCSEQ_RST10;
    end
    else
    begin
      done_s1_q <= conv_done_i;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      data_s1_q <= conv_data_i;
      data_s2_q <= data_s1_q;
      wb_ack_o <= acc;
      if (rd)
        wb_dat_o <= {24'h000000, rdata};
      ccf_q <= ccf_d;
      armed_q <= armed_d;
      seq_done_q <= seq_done_d;
      conv_start_o <= 1'b0;
      if (wr)
      begin
        case (idx)
          `ADCSEQ_IDX_CTL2: ctl2_q <= wb_dat_i[7:0];
          `ADCSEQ_IDX_CTL3: ctl3_q <= wb_dat_i[7:0];
          `ADCSEQ_IDX_TIM: tim_q <= wb_dat_i[7:0];
          `ADCSEQ_IDX_SEQ: seq_q <= wb_dat_i[7:0];
          default: ;
        endcase
      end
      if (st0_wr)
        cnt_q <= wb_dat_i[2:0];
      if (ctl_wr)
      begin
        state_q <= ST_START;
        cnt_q <= `ADCSEQ_CNT0;
        pos_q <= `ADCSEQ_CNT0;
        ch_q <= (idx == `ADCSEQ_IDX_SEQ) ? wb_dat_i[2:0] : code;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
            state_q <= ST_IDLE;
          ST_START:
          begin
            conv_start_o <= 1'b1;
            if (spec)
            begin
              if (chan[2] && chan != `ADCSEQ_SPEC_TOP)
                conv_sel_o <= {1'b1, chan};
              else
                conv_sel_o <= `ADCSEQ_SEL_RSV;
            end
            else
              conv_sel_o <= {1'b0, chan};
            state_q <= ST_WAIT;
          end
          ST_WAIT:
          begin
            if (conv_end)
            begin
              res_q[cnt_q] <= data_s2_q;
              cnt_q <= cnt_q + `ADCSEQ_CH_ONE;
              ch_q <= ch_q + `ADCSEQ_CH_ONE;
              if (pos_q == last_pos)
              begin
                pos_q <= `ADCSEQ_CNT0;
                cnt_q <= `ADCSEQ_CNT0;
                ch_q <= code;
                state_q <= seq_q[`ADCSEQ_SEQ_CONT] ? ST_START : ST_IDLE;
              end
              else
              begin
                pos_q <= pos_q + `ADCSEQ_CH_ONE;
                state_q <= ST_START;
              end
            end
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // adcseq_core
`default_nettype wire

//--- verif/adcseq_props.sv
// Port assertions for the sequencer.
// Bound into adcseq_core.
`timescale 1ns/10ps
`default_nettype none
module adcseq_props
(
  // Clock
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Converter
  input wire logic conv_start_o,
  input wire logic [3:0] conv_sel_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic rq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  a_ack_reply: assert property (rq |=> wb_ack_o) else $error("no ack");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper data");
  a_stat_pad:
    assert property (rq && !wb_we_i && wb_adr_i == 10'h198 |=> wb_dat_o[6:3] == 4'h0) else $error("stat pad");
  a_ctl_restart:
    assert property (rq && wb_we_i && wb_adr_i[9:3] == 7'h32 |-> ##[1:8] conv_start_o) else $error("no start");
  a_start_once: assert property (conv_start_o |=> !conv_start_o) else $error("long start");
  a_start_busy: assert property (conv_start_o |-> busy_o) else $error("idle start");
  a_spec_code: assert property (conv_start_o && conv_sel_o[3] |-> conv_sel_o[2]) else $error("bad sel");
endmodule // adcseq_props
bind adcseq_core adcseq_props u_props (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .conv_start_o(conv_start_o), .conv_sel_o(conv_sel_o), .busy_o(busy_o));
`default_nettype wire

//--- verif/adcseq_analog.sv
// Analog core model: one result per start.
// Answers lag+3 clocks after the edge that samples start.
`timescale 1ns/10ps
`default_nettype none
module adcseq_analog
(
  // Handshake
  input wire logic clk,
  input wire logic start,
  input wire logic [3:0] sel,
  input wire logic [2:0] lag,
  output logic done = 1'h0,
  output logic [9:0] data = 10'h000
);
  logic [3:0] s_q = 4'hF;
  integer cnt = -1;
  always @(posedge clk)
  begin
    cnt <= start ? lag + 2 : cnt - (cnt >= 0);
    if (start)
    begin
      done <= 1'h0;
      data <= ~data;
      s_q <= sel;
    end
    else if (cnt == 0)
    begin
      done <= 1'h1;
      data <= s_q == 4'hC ? 10'h3FF : s_q == 4'hD ? 10'h000 : s_q == 4'hE ? 10'h17F : {2'h0, 4'hA, s_q};
    end
  end
endmodule // adcseq_analog
`default_nettype wire

//--- verif/adcseq_tb.sv
// Bench: bus driver and result model.
// Uses adcseq_analog as converter.
`timescale 1ns/10ps
`default_nettype none
module adc_sequence_channel_status_tb;
  logic clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, we = 1'h0;
  logic [9:0] adr = 10'h000;
  logic [7:0] wd = 8'h00, rd;
  logic [31:0] seed = 32'h0000D275;
  wire logic [31:0] dat_o;
  wire logic ack, start, done, busy;
  wire logic [3:0] sel;
  wire logic [9:0] data;
  integer mismatches = 0, tests_run = 0, n, i, k, len, ch;
  int q[$];
  `define CHK(m, e, g) tests_run++; if ((g) !== (e)) begin mismatches++; $display("wrong value %s %h %h", m, e, g); end
  always #2.5 clk = ~clk;
  adcseq_core DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i({24'h000000, wd}), .wb_dat_o(dat_o), .wb_ack_o(ack), .conv_start_o(start),
    .conv_sel_o(sel), .conv_done_i(done), .conv_data_i(data), .busy_o(busy));
  adcseq_analog u_model (.clk(clk), .start(start), .sel(sel), .lag(seed[10:8]), .done(done), .data(data));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task hang(input logic bad);
    mismatches += bad;
    if (bad)
      report_and_stop;
  endtask
  task bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    we <= w;
    adr <= {idx, 2'h0};
    wd <= d;
    for (i = 0; i < 20 && ack !== 1'h1; i++)
      @(posedge clk);
    hang(ack !== 1'h1);
    rd = dat_o[7:0];
    cyc <= 1'h0;
    we <= 1'h0;
  endtask
  task idle;
    for (i = 0; i < 9 && busy !== 1'h1; i++)
      @(posedge clk);
    for (i = 0; i < 3000 && busy !== 1'h0; i++)
      @(posedge clk);
    hang(busy !== 1'h0);
  endtask
  task run(input logic [7:0] c3, input logic [7:0] s, input logic fast);
    len = s[6] ? 8 : c3[3] ? 1 : 4;
    q = {};
    for (k = 0; k < len; k++)
    begin
      ch = s[4] ? (s[2:0] + k) % 8 : s[2:0];
      q.push_back(!s[3] ? 8'hA0 + ch : ch == 4 ? 8'hFF : ch == 5 ? 8'h00 : ch == 6 ? 8'h7F : 8'hAF);
    end
    bus(8'h62, 1'h1, {7'h00, fast});
    bus(8'h63, 1'h1, c3);
    bus(8'h65, 1'h1, s);
    bus(8'h66, 1'h0, 8'h00);
    `CHK("scf", 1'h0, rd[7])
    bus(8'h64, 1'h1, 8'h00);
    idle;
    bus(8'h66, 1'h0, 8'h00);
    `CHK("scf", 1'h1, rd[7])
    bus(8'h67, 1'h0, 8'h00);
    `CHK("ccf", (1 << len) - 1, rd)
    for (k = 0; k < len; k++)
    begin
      bus(8'h70 + k[7:0], 1'h0, 8'h00);
      `CHK("res", q[k], rd)
    end
    bus(8'h67, 1'h0, 8'h00);
    `CHK("ccf", 8'h00, rd)
    bus(8'h66, 1'h0, 8'h00);
    `CHK("scf", !fast, rd[7])
  endtask
  initial
  begin
    repeat (5)
      @(posedge clk);
    rst_n <= 1'h1;
    bus(8'h67, 1'h1, 8'hFF);
    bus(8'h67, 1'h0, 8'h00);
    `CHK("stat1", 8'h00, rd)
    for (n = 0; n < 24; n++)
    begin
      seed = lfsr(seed);
      run({4'h0, seed[7] & (seed[6] | !seed[4]), 3'h0}, {1'h0, seed[6:0] & 7'h5F}, n > 11);
    end
    bus(8'h65, 1'h1, 8'h21);
    rd = 8'h00;
    for (k = 0; k < 300 && rd[7] !== 1'h1; k++)
      bus(8'h66, 1'h0, 8'h00);
    `CHK("scf", 1'h1, rd[7])
    `CHK("busy", 1'h1, busy)
    bus(8'h65, 1'h1, 8'h01);
    idle;
    bus(8'h67, 1'h0, 8'h00);
    `CHK("ccf", 8'h0F, rd)
    for (k = 0; k < 4; k++)
    begin
      bus(8'h70 + k[7:0], 1'h0, 8'h00);
      `CHK("res", 8'hA1, rd)
    end
    bus(8'h65, 1'h1, 8'h40);
    idle;
    bus(8'h64, 1'h1, 8'h00);
    bus(8'h67, 1'h0, 8'h00);
    `CHK("ccf", 8'h00, rd)
    report_and_stop;
  end
endmodule // adc_sequence_channel_status_tb
`default_nettype wire
